// ==== pkg/scm_pkg.sv ====
// register map, field positions, reset values and timing counts for the clock control block
package scm_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ADDR_W = 4;
  // byte offsets of the three control registers
  localparam logic [3:0] SYSCLK_CONTROL_OFS = 4'h0;
  localparam logic [3:0] FAST_RC_CONTROL_OFS = 4'h4;
  localparam logic [3:0] CRYSTAL_CONTROL_OFS = 4'h8;
  // sysclk_control fields
  localparam int SCC_HALT_SLOW_BIT = 0;
  localparam int SCC_HALT_FAST_BIT = 1;
  localparam int SCC_SRC_BIT = 2;
  localparam int SCC_SEL_LSB = 5;
  localparam int SCC_SEL_MSB = 7;
  localparam logic [7:0] SCC_MASK = 8'he7;
  localparam logic [7:0] SCC_RESET = 8'h00;
  // fast_rc_control fields
  localparam int FRC_EN_BIT = 0;
  localparam int FRC_FLAG_BIT = 1;
  localparam int FRC_FREQ_LSB = 2;
  localparam int FRC_FREQ_MSB = 3;
  localparam logic [7:0] FRC_RESET = 8'h01;
  // crystal_control fields
  localparam int XTC_EN_BIT = 0;
  localparam int XTC_FLAG_BIT = 1;
  localparam int XTC_SPEED_BIT = 2;
  localparam logic [7:0] XTC_RESET = 8'h00;
  localparam logic [2:0] SEL_SLOW = 3'h7;
  // settle times in microseconds, counted in aclk cycles (the MHz factor rounds down)
  localparam int unsigned FAST_RC_SETTLE_US = 16;
  localparam int unsigned XTAL_QUICK_US = 200;
  localparam int unsigned XTAL_LOWPWR_US = 1000;
  localparam int unsigned FAST_RC_SETTLE_CYC = (FAST_RC_SETTLE_US * (CLK_HZ / 1000000));
  localparam int unsigned XTAL_QUICK_CYC = (XTAL_QUICK_US * (CLK_HZ / 1000000));
  localparam int unsigned XTAL_LOWPWR_CYC = (XTAL_LOWPWR_US * (CLK_HZ / 1000000));
  // fast rc frequency encodings
  localparam logic [1:0] FREQ_8M = 2'h0;
  localparam logic [1:0] FREQ_12M = 2'h1;
  localparam logic [1:0] FREQ_16M = 2'h2;
  typedef enum logic [1:0] {
    SCM_FREQ_8, SCM_FREQ_12, SCM_FREQ_16
  } scm_freq_t;
  typedef enum logic [2:0] {
    SCM_FAST, SCM_SLOW, SCM_IDLE_SLOW_ONLY, SCM_IDLE_BOTH_CLOCKS, SCM_IDLE_FAST_ONLY, SCM_SLEEP
  } scm_mode_t;
endpackage : scm_pkg

// ==== core/scm_settle.sv ====
// settle timer: flag clears on restart or disable, sets after a programmable count
`timescale 1ns/1ps
`default_nettype none
module scm_settle #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic enable,
  input wire logic restart,
  input wire logic [CNT_W-1:0] count,
  output logic stable
);
  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      stable <= 1'b0;
    end else if (ce) begin
      if (!enable || restart) begin
        cnt_reg <= '0;
        stable <= 1'b0;
      end else if (!stable) begin
        if (cnt_reg + 1'b1 >= count) begin
          stable <= 1'b1;
        end
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule : scm_settle
`default_nettype wire

// ==== core/scm_divider.sv ====
// free running prescaler for the fast clock, one enable pulse per selected ratio
`timescale 1ns/1ps
`default_nettype none
module scm_divider (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [5:0] cnt_reg;
  logic [5:0] mask;

  always_comb begin
    mask = 6'((7'h01 << sel) - 7'h01);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      if (run) begin
        cnt_reg <= cnt_reg + 6'h01;
        tick <= ((cnt_reg & mask) == mask);
      end else begin
        tick <= 1'b0;
      end
    end
  end
endmodule : scm_divider
`default_nettype wire

// ==== core/scm_clock_ctrl.sv ====
// clock source, divider and operating mode control with an axi4-lite register port
`timescale 1ns/1ps
`default_nettype none
module scm_clock_ctrl
#(
  parameter int unsigned FAST_RC_SETTLE_CYCLES = scm_pkg::FAST_RC_SETTLE_CYC,
  parameter int unsigned XTAL_QUICK_CYCLES = scm_pkg::XTAL_QUICK_CYC,
  parameter int unsigned XTAL_LOWPWR_CYCLES = scm_pkg::XTAL_LOWPWR_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [scm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [scm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic crystal_pin_a_in,
  input wire logic crystal_pin_share,
  output logic crystal_pins_osc,
  output logic crystal_pins_gpio,
  output logic fast_rc_osc_on,
  output logic [1:0] fast_rc_osc_freq,
  output logic slow_rc_osc_on,
  output logic crystal_osc_on,
  output logic crystal_osc_quick,
  output logic fast_clk_en,
  output logic slow_clk_en,
  output logic system_clk_en,
  output logic system_clk_is_slow,
  output logic cpu_run,
  output logic [2:0] op_mode
);
  import scm_pkg::*;

  logic [7:0] scc_reg;
  logic [7:0] frc_reg;
  logic [7:0] xtc_reg;
  logic [2:0] act_sel_reg;
  logic act_src_reg;
  logic [1:0] act_freq_reg;
  scm_mode_t mode_reg;
  scm_mode_t mode_next;
  scm_mode_t mode_view;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic frc_stable;
  logic xtal_stable;
  logic frc_restart;
  logic xtal_restart;
  logic div_tick;
  logic slow_stable;
  logic xtal_in_use;
  logic xtal_is_sys;
  logic halted;
  logic fast_needed;
  logic slow_needed;
  logic sys_on;
  logic [15:0] xtal_count;

  // 11 decodes as 8 MHz
  function automatic logic [1:0] freq_decode(input logic [1:0] f);
    freq_decode = (f == 2'h3) ? FREQ_8M : f;
  endfunction : freq_decode

  // ---------------- axi4-lite write side
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (ce) begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg == SYSCLK_CONTROL_OFS || aw_addr_reg == FAST_RC_CONTROL_OFS ||
                        aw_addr_reg == CRYSTAL_CONTROL_OFS) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- software registers; only byte lane 0 carries bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scc_reg <= SCC_RESET;
      frc_reg <= FRC_RESET;
      xtc_reg <= XTC_RESET;
    end else if (ce && wr_fire && w_strb_reg[0]) begin
      unique case (aw_addr_reg)
        SYSCLK_CONTROL_OFS: scc_reg <= w_data_reg[7:0] & SCC_MASK;
        FAST_RC_CONTROL_OFS: begin
          frc_reg[FRC_EN_BIT] <= w_data_reg[FRC_EN_BIT];
          frc_reg[FRC_FREQ_MSB:FRC_FREQ_LSB] <= w_data_reg[FRC_FREQ_MSB:FRC_FREQ_LSB];
        end
        CRYSTAL_CONTROL_OFS: begin
          xtc_reg[XTC_EN_BIT] <= w_data_reg[XTC_EN_BIT];
          if (!xtal_is_sys) begin
            xtc_reg[XTC_SPEED_BIT] <= w_data_reg[XTC_SPEED_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // a restart pulse clears the stable flag before it can set again
  assign frc_restart = wr_fire && w_strb_reg[0] && aw_addr_reg == FAST_RC_CONTROL_OFS &&
    ((w_data_reg[FRC_EN_BIT] && !frc_reg[FRC_EN_BIT]) ||
     (freq_decode(w_data_reg[FRC_FREQ_MSB:FRC_FREQ_LSB]) !=
      freq_decode(frc_reg[FRC_FREQ_MSB:FRC_FREQ_LSB])));
  assign xtal_restart = wr_fire && w_strb_reg[0] && aw_addr_reg == CRYSTAL_CONTROL_OFS &&
    w_data_reg[XTC_EN_BIT] && !xtc_reg[XTC_EN_BIT];

  // speed mode only shortens start-up; once running the oscillator keeps going
  assign xtal_count = xtc_reg[XTC_SPEED_BIT] ? 16'(XTAL_QUICK_CYCLES)
                                              : 16'(XTAL_LOWPWR_CYCLES);

  scm_settle #(.CNT_W(16)) u_frc_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(fast_rc_osc_on),
    .restart(frc_restart),
    .count(16'(FAST_RC_SETTLE_CYCLES)),
    .stable(frc_stable)
  );

  // speed-mode change does not restart the timer, so clearing it never stops the crystal
  scm_settle #(.CNT_W(16)) u_xtal_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(crystal_osc_on),
    .restart(xtal_restart),
    .count(xtal_count),
    .stable(xtal_stable)
  );

  assign slow_stable = act_src_reg ? xtal_stable : 1'b1;
  assign xtal_is_sys = act_sel_reg == SEL_SLOW && act_src_reg;
  assign xtal_in_use = xtc_reg[XTC_EN_BIT] || scc_reg[SCC_SRC_BIT];

  // ---------------- glitch-free switch: the old setting stays until the target is stable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_sel_reg <= 3'h0;
      act_src_reg <= 1'b0;
      act_freq_reg <= FREQ_8M;
    end else if (ce) begin
      if (frc_stable) begin
        act_freq_reg <= freq_decode(frc_reg[FRC_FREQ_MSB:FRC_FREQ_LSB]);
      end
      if (scc_reg[SCC_SRC_BIT] == 1'b0 || xtal_stable) begin
        act_src_reg <= scc_reg[SCC_SRC_BIT];
      end
      // divider changes land on a prescaler boundary, or at once while the slow clock is applied
      if (scc_reg[SCC_SEL_MSB:SCC_SEL_LSB] == SEL_SLOW) begin
        if ((scc_reg[SCC_SRC_BIT] ? xtal_stable : 1'b1) &&
            (act_sel_reg == SEL_SLOW || div_tick)) begin
          act_sel_reg <= SEL_SLOW;
        end
      end else if (frc_stable && (act_sel_reg == SEL_SLOW || div_tick)) begin
        act_sel_reg <= scc_reg[SCC_SEL_MSB:SCC_SEL_LSB];
      end
    end
  end

  // ---------------- operating mode
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      SCM_FAST, SCM_SLOW: begin
        if (halt_req) begin
          unique case ({scc_reg[SCC_HALT_FAST_BIT], scc_reg[SCC_HALT_SLOW_BIT]})
            2'b00: mode_next = SCM_SLEEP;
            2'b01: mode_next = SCM_IDLE_SLOW_ONLY;
            2'b11: mode_next = SCM_IDLE_BOTH_CLOCKS;
            2'b10: mode_next = SCM_IDLE_FAST_ONLY;
          endcase
        end else begin
          mode_next = (act_sel_reg == SEL_SLOW) ? SCM_SLOW : SCM_FAST;
        end
      end
      SCM_IDLE_SLOW_ONLY, SCM_IDLE_BOTH_CLOCKS, SCM_IDLE_FAST_ONLY, SCM_SLEEP: begin
        if (wake_req) begin
          mode_next = (act_sel_reg == SEL_SLOW) ? SCM_SLOW : SCM_FAST;
        end
      end
      default: mode_next = SCM_FAST;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= SCM_FAST;
    end else if (ce) begin
      mode_reg <= mode_next;
    end
  end

  assign halted = mode_reg != SCM_FAST && mode_reg != SCM_SLOW;
  // run modes follow the applied selection, so op_mode and clock outputs change together
  assign mode_view = halted ? mode_reg : ((act_sel_reg == SEL_SLOW) ? SCM_SLOW : SCM_FAST);
  // fast oscillator: always on in fast mode, enable bit in slow mode, halt enable when halted
  assign fast_needed = (mode_view == SCM_FAST) ||
                       (mode_view == SCM_SLOW && frc_reg[FRC_EN_BIT]) ||
                       mode_reg == SCM_IDLE_BOTH_CLOCKS || mode_reg == SCM_IDLE_FAST_ONLY;
  assign slow_needed = !halted || mode_reg == SCM_IDLE_SLOW_ONLY ||
                       mode_reg == SCM_IDLE_BOTH_CLOCKS;
  always_comb begin
    unique case (mode_reg)
      SCM_FAST, SCM_SLOW, SCM_IDLE_BOTH_CLOCKS: sys_on = 1'b1;
      SCM_IDLE_SLOW_ONLY: sys_on = act_sel_reg == SEL_SLOW;
      SCM_IDLE_FAST_ONLY: sys_on = act_sel_reg != SEL_SLOW;
      SCM_SLEEP: sys_on = 1'b0;
      default: sys_on = 1'b0;
    endcase
  end

  scm_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .run(frc_stable),
    .sel(act_sel_reg),
    .tick(div_tick)
  );

  // ---------------- registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_rc_osc_on <= 1'b0;
      fast_rc_osc_freq <= FREQ_8M;
      slow_rc_osc_on <= 1'b0;
      crystal_osc_on <= 1'b0;
      crystal_osc_quick <= 1'b0;
      fast_clk_en <= 1'b0;
      slow_clk_en <= 1'b0;
      system_clk_en <= 1'b0;
      system_clk_is_slow <= 1'b0;
      cpu_run <= 1'b0;
      op_mode <= 3'h0;
      crystal_pins_osc <= 1'b0;
      crystal_pins_gpio <= 1'b0;
    end else if (ce) begin
      fast_rc_osc_on <= fast_needed;
      fast_rc_osc_freq <= act_freq_reg;
      slow_rc_osc_on <= 1'b1;
      crystal_osc_on <= xtc_reg[XTC_EN_BIT] && mode_reg != SCM_SLEEP;
      crystal_osc_quick <= xtc_reg[XTC_SPEED_BIT];
      fast_clk_en <= frc_stable && fast_needed && div_tick;
      slow_clk_en <= slow_needed && slow_stable;
      system_clk_en <= sys_on && ((act_sel_reg == SEL_SLOW) ? slow_stable
                                                            : (frc_stable && div_tick));
      system_clk_is_slow <= act_sel_reg == SEL_SLOW;
      cpu_run <= !halted;
      op_mode <= mode_view;
      crystal_pins_osc <= xtal_in_use;
      crystal_pins_gpio <= !xtal_in_use && crystal_pin_share;
    end
  end

  // ---------------- axi4-lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          SYSCLK_CONTROL_OFS: s_axi_rdata <= {24'h000000, scc_reg};
          FAST_RC_CONTROL_OFS: s_axi_rdata <= {28'h0000000, frc_reg[3:2], frc_stable,
                                               frc_reg[FRC_EN_BIT]};
          CRYSTAL_CONTROL_OFS: s_axi_rdata <= {29'h00000000, xtc_reg[XTC_SPEED_BIT],
                                               xtal_stable, xtc_reg[XTC_EN_BIT]};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : scm_clock_ctrl
`default_nettype wire

// ==== dv/scm_clock_ctrl_asserts.sv ====
// port-level checks for the clock control block
`timescale 1ns/1ps
`default_nettype none
module scm_clock_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic crystal_pins_osc,
  input wire logic crystal_pins_gpio,
  input wire logic fast_rc_osc_on,
  input wire logic [1:0] fast_rc_osc_freq,
  input wire logic slow_rc_osc_on,
  input wire logic fast_clk_en,
  input wire logic slow_clk_en,
  input wire logic system_clk_en,
  input wire logic system_clk_is_slow,
  input wire logic cpu_run,
  input wire logic [2:0] op_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // modes must hold two edges, so output regs updated one edge apart do not trip
  chk_pins_exclusive: assert property (!(crystal_pins_osc && crystal_pins_gpio))
    else $error("crystal pins claimed as oscillator and gpio");
  chk_sleep_all_off: assert property (op_mode == 3'h5 && $past(op_mode) == 3'h5 |->
    !cpu_run && !fast_rc_osc_on && !fast_clk_en && !slow_clk_en && !system_clk_en)
    else $error("clock running in sleep");
  chk_idle_slow_only: assert property (op_mode == 3'h2 && $past(op_mode) == 3'h2 |->
    !cpu_run && !fast_rc_osc_on && !fast_clk_en && slow_clk_en)
    else $error("wrong clocks in slow-only idle");
  chk_idle_both_on: assert property (op_mode == 3'h3 && $past(op_mode) == 3'h3 |->
    !cpu_run && fast_rc_osc_on && slow_clk_en)
    else $error("wrong clocks in both-clock idle");
  chk_idle_fast_only: assert property (op_mode == 3'h4 && $past(op_mode) == 3'h4 |->
    !cpu_run && fast_rc_osc_on && !slow_clk_en)
    else $error("wrong clocks in fast-only idle");
  chk_fast_rc_runs: assert property (op_mode == 3'h0 && $past(op_mode) == 3'h0
    && $past(cpu_run) |-> fast_rc_osc_on)
    else $error("fast mode without fast oscillator");
  chk_slow_sysclk: assert property (op_mode == 3'h1 && $past(op_mode) == 3'h1 |->
    system_clk_is_slow && slow_clk_en && cpu_run)
    else $error("slow mode not on slow clock");
  chk_slow_rc_on: assert property ($past(aresetn) && $past(aresetn, 2) |-> slow_rc_osc_on)
    else $error("slow rc oscillator stopped");
  chk_freq_legal: assert property (fast_rc_osc_freq != 2'h3)
    else $error("applied fast frequency code illegal");
endmodule : scm_clock_ctrl_chk
bind scm_clock_ctrl scm_clock_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .crystal_pins_osc(crystal_pins_osc), .crystal_pins_gpio(crystal_pins_gpio),
  .fast_rc_osc_on(fast_rc_osc_on), .fast_rc_osc_freq(fast_rc_osc_freq),
  .slow_rc_osc_on(slow_rc_osc_on), .fast_clk_en(fast_clk_en), .slow_clk_en(slow_clk_en),
  .system_clk_en(system_clk_en), .system_clk_is_slow(system_clk_is_slow),
  .cpu_run(cpu_run), .op_mode(op_mode));
`default_nettype wire

// ==== dv/scm_xtal_model.sv ====
// behavioural crystal on the sense pin
`timescale 1ns/1ps
`default_nettype none
module scm_xtal_model (
  input wire logic aclk,
  input wire logic osc_on,
  output logic pin_a
);
  logic [1:0] ph_reg = 2'h0;
  initial pin_a = 1'b0;
  // same swing in either speed mode; a stopped pin flips so stale levels never look live
  always @(posedge aclk) begin
    ph_reg <= ph_reg + 2'h1;
    if (!osc_on || ph_reg == 2'h3) begin
      pin_a <= ~pin_a;
    end
  end
endmodule : scm_xtal_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scm_pkg::*;
  localparam logic [2:0] HM [4] = '{3'h5, 3'h2, 3'h4, 3'h3};
  logic aclk, aresetn, halt_req, wake_req, share, xpin, awv, wv, bry, arv, rry;
  logic [3:0] awa, ara, strb;
  logic [31:0] wd, rd_d, rv;
  logic awr, wr_r, bv, arr, rvl, p_osc, p_gpio, f_on, s_on, x_on, x_q, f_en, s_en, y_en;
  logic is_slow, cpu_run;
  logic [1:0] br, rr, freq, prev;
  logic [2:0] op_mode;
  logic [34:0] exp_q[$];
  int fails = 0;
  int checks_done = 0;
  int seed = 3206;
  int i, n;
  scm_clock_ctrl #(.FAST_RC_SETTLE_CYCLES(16), .XTAL_QUICK_CYCLES(8),
    .XTAL_LOWPWR_CYCLES(60)) DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rvl),
    .s_axi_rready(rry), .halt_req(halt_req), .wake_req(wake_req),
    .crystal_pin_a_in(xpin), .crystal_pin_share(share), .crystal_pins_osc(p_osc),
    .crystal_pins_gpio(p_gpio), .fast_rc_osc_on(f_on), .fast_rc_osc_freq(freq),
    .slow_rc_osc_on(s_on), .crystal_osc_on(x_on), .crystal_osc_quick(x_q),
    .fast_clk_en(f_en), .slow_clk_en(s_en), .system_clk_en(y_en),
    .system_clk_is_slow(is_slow), .cpu_run(cpu_run), .op_mode(op_mode));
  scm_xtal_model u_xtal (.aclk(aclk), .osc_on(x_on), .pin_a(xpin));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [34:0] rok(input logic [7:0] v);
    return {1'b1, 2'h0, 24'h0, v};
  endfunction : rok
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  // top bit of a note says whether read data is compared
  always @(posedge aclk) begin : mon
    logic [34:0] e;
    if (exp_q.size() > 0 && ((bv && bry) || (rvl && rry))) begin
      e = exp_q.pop_front();
      check({e[34], bv ? br : rr, (e[34] && !bv) ? rd_d : 32'h0}, e);
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    int k;
    logic at, wt, bt, pa, pw, pb;
    rv = $random(seed);
    exp_q.push_back({1'b0, 2'h0, 32'h0});
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    awa <= a;
    wd <= {rv[23:0], d};
    strb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    // local flags: the nonblocking drives have not landed when the loop test runs
    for (k = 0; k < 50 && (pa || pw || pb); k++) begin
      @(negedge aclk);
      at = pa && awr;
      wt = pw && wr_r;
      bt = pb && bv;
      @(posedge aclk);
      if (at) awv <= 1'b0;
      if (wt) wv <= 1'b0;
      if (bt) bry <= 1'b0;
      pa = pa && !at;
      pw = pw && !wt;
      pb = pb && !bt;
    end
    if (k >= 50) begin
      fails++;
      tally_and_finish();
    end
    // one idle edge so the next request never lands in the step that released this one
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [34:0] e);
    int k;
    logic at, rt, pa, pr;
    exp_q.push_back(e);
    pa = 1'b1;
    pr = 1'b1;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (k = 0; k < 50 && (pa || pr); k++) begin
      @(negedge aclk);
      at = pa && arr;
      rt = pr && rvl;
      @(posedge aclk);
      if (at) arv <= 1'b0;
      if (rt) rry <= 1'b0;
      pa = pa && !at;
      pr = pr && !rt;
    end
    if (k >= 50) begin
      fails++;
      tally_and_finish();
    end
    @(posedge aclk);
  endtask : rd
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end
  initial begin
    {aresetn, halt_req, wake_req, awv, wv, bry, arv, rry} = 8'h00;
    {awa, ara, strb, wd} = 44'h0;
    share = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(40);
    rd(SYSCLK_CONTROL_OFS, rok(SCC_RESET));
    rd(FAST_RC_CONTROL_OFS, rok(FRC_RESET | 8'h02));
    rd(CRYSTAL_CONTROL_OFS, rok(XTC_RESET));
    rd(4'hc, {1'b0, 2'h2, 32'h0});
    check(35'({p_osc, p_gpio}), 35'(2'b01));
    prev = 2'h0;
    // software keeps the field matching the configured frequency on each pass
    for (i = 1; i < 5; i++) begin
      wr(FAST_RC_CONTROL_OFS, {4'h0, 2'(i), 2'h1}, 4'hf);
      // 11 to 00 keeps 8 MHz, so the last pass does not restart the flag
      rd(FAST_RC_CONTROL_OFS, rok({4'h0, 2'(i), (i == 4), 1'b1}));
      check(35'(freq), 35'(prev));
      cyc(30);
      rd(FAST_RC_CONTROL_OFS, rok({4'h0, 2'(i), 2'h3}));
      prev = (2'(i) == 2'h3) ? FREQ_8M : 2'(i);
      check(35'(freq), 35'(prev));
    end
    wr(CRYSTAL_CONTROL_OFS, 8'h01, 4'hf);
    rd(CRYSTAL_CONTROL_OFS, rok(8'h01));
    check(35'({x_on, x_q, p_osc, p_gpio}), 35'(4'b1010));
    cyc(20);
    rd(CRYSTAL_CONTROL_OFS, rok(8'h01));
    cyc(50);
    rd(CRYSTAL_CONTROL_OFS, rok(8'h03));
    wr(CRYSTAL_CONTROL_OFS, 8'h00, 4'hf);
    wr(CRYSTAL_CONTROL_OFS, 8'h05, 4'hf);
    cyc(12);
    rd(CRYSTAL_CONTROL_OFS, rok(8'h07));
    wr(CRYSTAL_CONTROL_OFS, 8'h01, 4'hf);
    rd(CRYSTAL_CONTROL_OFS, rok(8'h03));
    check(35'({x_on, x_q}), 35'(2'b10));
    wr(SYSCLK_CONTROL_OFS, {SEL_SLOW, 5'h04}, 4'h1);
    cyc(20);
    check(35'({is_slow, op_mode}), 35'({1'b1, 3'h1}));
    wr(CRYSTAL_CONTROL_OFS, 8'h05, 4'hf);
    rd(CRYSTAL_CONTROL_OFS, rok(8'h03));
    rv = $random(seed);
    wr(SYSCLK_CONTROL_OFS, rv[7:0], 4'he);
    rd(SYSCLK_CONTROL_OFS, rok({SEL_SLOW, 5'h04}));
    wr(FAST_RC_CONTROL_OFS, 8'h00, 4'hf);
    cyc(4);
    check(35'(f_on), 35'(1'b0));
    wr(FAST_RC_CONTROL_OFS, 8'h01, 4'hf);
    wr(SYSCLK_CONTROL_OFS, 8'h00, 4'h1);
    wr(CRYSTAL_CONTROL_OFS, 8'h00, 4'hf);
    cyc(30);
    check(35'({is_slow, op_mode, p_osc, p_gpio}), 35'(6'b000001));
    for (i = 0; i < 7; i++) begin
      wr(SYSCLK_CONTROL_OFS, {3'(i), 5'h0}, 4'h1);
      cyc(80);
      n = 0;
      repeat (128) begin
        @(negedge aclk);
        n = n + int'(y_en);
      end
      @(posedge aclk);
      check(35'(n), 35'(128 >> i));
    end
    for (i = 0; i < 4; i++) begin
      wr(SYSCLK_CONTROL_OFS, {6'h0, 2'(i)}, 4'h1);
      halt_req <= 1'b1;
      @(posedge aclk);
      halt_req <= 1'b0;
      cyc(6);
      check(35'({cpu_run, op_mode}), 35'({1'b0, HM[i]}));
      wake_req <= 1'b1;
      @(posedge aclk);
      wake_req <= 1'b0;
      cyc(6);
      check(35'({cpu_run, op_mode}), 35'(4'h8));
    end
    cyc(4);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
